// ==== hdl/ocs_params.svh ====
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

// ==========================================================
// register offsets
`define OCS_SIX_DRIVER_OFS 8'h0f
`define OCS_SIX_UPPER_OFS 8'h10
`define OCS_SIX_LOWER_OFS 8'h11
`define OCS_SEVEN_DRIVER_OFS 8'h12
`define OCS_SEVEN_UPPER_OFS 8'h13
`define OCS_SEVEN_LOWER_OFS 8'h14

// ==========================================================
// writable bits and reset values
`define OCS_DRIVER_MASK 16'h1fdf
`define OCS_UPPER_MASK 16'h0fff
`define OCS_LOWER_MASK 16'hffff
`define OCS_REG_RESET 16'h0000

// ==========================================================
// field positions of the driver configuration word
`define OCS_PRESCALE_MSB 12
`define OCS_PRESCALE_LSB 10
`define OCS_FRAC_EN_BIT 9
`define OCS_SLEW_BIT 8
`define OCS_NEG_EN_BIT 7
`define OCS_POS_EN_BIT 6
`define OCS_DRV_MSB 4
`define OCS_DRV_LSB 3
`define OCS_ENABLE_MSB 2
`define OCS_ENABLE_LSB 1
`define OCS_SUPPLY_BIT 0

// ==========================================================
// field positions of the divider words
`define OCS_INTDIV_MSB 11
`define OCS_INTDIV_LSB 4
`define OCS_FRAC_HI_MSB 3
`define OCS_FRAC_HI_LSB 0

// ==========================================================
// prescale codes and ratios
`define OCS_PRE_DIV2 3'h0
`define OCS_PRE_DIV3 3'h1
`define OCS_PRE_DIV1 3'h7
`define OCS_RATIO_ONE 2'h1
`define OCS_RATIO_TWO 2'h2
`define OCS_RATIO_THREE 2'h3

`endif

// ==== hdl/ocs_pkg.sv ====
package ocs_pkg;
  // output driver family
  typedef enum logic [1:0] {OCS_DRV_DIFF, OCS_DRV_CMOS, OCS_DRV_HCSL} ocs_drv_e;
  // output enable mode
  typedef enum logic [1:0] {OCS_OUT_OFF, OCS_OUT_RUN, OCS_OUT_LOW, OCS_OUT_HIGH} ocs_mode_e;
endpackage : ocs_pkg

// ==== hdl/ocs_chan_decode.sv ====
`timescale 1ns/1ps
`include "ocs_params.svh"
module ocs_chan_decode (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] driver_word,
  input wire logic [15:0] upper_word,
  input wire logic [15:0] lower_word,
  output logic [1:0] prescale_ratio,
  output logic prescale_bad,
  output logic frac_en,
  output logic [8:0] int_ratio,
  output logic [19:0] frac_word,
  output ocs_pkg::ocs_mode_e out_mode,
  output logic clk_run,
  output logic static_level,
  output ocs_pkg::ocs_drv_e driver,
  output logic slew_slow,
  output logic pos_en,
  output logic neg_en,
  output logic neg_without_pos,
  output logic supply_high
);
  logic [1:0] nxt_prescale_ratio;
  logic nxt_prescale_bad;
  logic [8:0] nxt_int_ratio;
  ocs_pkg::ocs_mode_e nxt_out_mode;
  ocs_pkg::ocs_drv_e nxt_driver;
  logic [2:0] code;

  // ==========================================================
  // field decode
  always_comb begin
    code = driver_word[`OCS_PRESCALE_MSB:`OCS_PRESCALE_LSB];
    nxt_prescale_bad = 1'b0;
    unique case (code)
      `OCS_PRE_DIV2: nxt_prescale_ratio = `OCS_RATIO_TWO;
      `OCS_PRE_DIV3: nxt_prescale_ratio = `OCS_RATIO_THREE;
      `OCS_PRE_DIV1: nxt_prescale_ratio = `OCS_RATIO_ONE;
      default: begin
        // reserved codes fall back to pass-through rather than an odd ratio
        nxt_prescale_ratio = `OCS_RATIO_ONE;
        nxt_prescale_bad = 1'b1;
      end
    endcase
    // disabled fraction path means the prescaler is bypassed
    if (!driver_word[`OCS_FRAC_EN_BIT]) begin
      nxt_prescale_ratio = `OCS_RATIO_ONE;
      nxt_prescale_bad = 1'b0;
    end
    nxt_int_ratio = {1'b0, upper_word[`OCS_INTDIV_MSB:`OCS_INTDIV_LSB]} + 9'h001;
    unique case (driver_word[`OCS_ENABLE_MSB:`OCS_ENABLE_LSB])
      2'h0: nxt_out_mode = ocs_pkg::OCS_OUT_OFF;
      2'h1: nxt_out_mode = ocs_pkg::OCS_OUT_RUN;
      2'h2: nxt_out_mode = ocs_pkg::OCS_OUT_LOW;
      2'h3: nxt_out_mode = ocs_pkg::OCS_OUT_HIGH;
    endcase
    unique case (driver_word[`OCS_DRV_MSB:`OCS_DRV_LSB])
      2'h2: nxt_driver = ocs_pkg::OCS_DRV_CMOS;
      2'h3: nxt_driver = ocs_pkg::OCS_DRV_HCSL;
      default: nxt_driver = ocs_pkg::OCS_DRV_DIFF;
    endcase
  end

  // ==========================================================
  // registered decode outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      prescale_ratio <= `OCS_RATIO_ONE;
      prescale_bad <= 1'b0;
      frac_en <= 1'b0;
      int_ratio <= 9'h001;
      frac_word <= 20'h00000;
      out_mode <= ocs_pkg::OCS_OUT_OFF;
      clk_run <= 1'b0;
      static_level <= 1'b0;
      driver <= ocs_pkg::OCS_DRV_DIFF;
      slew_slow <= 1'b0;
      pos_en <= 1'b0;
      neg_en <= 1'b0;
      neg_without_pos <= 1'b0;
      supply_high <= 1'b0;
    end else begin
      prescale_ratio <= nxt_prescale_ratio;
      prescale_bad <= nxt_prescale_bad;
      frac_en <= driver_word[`OCS_FRAC_EN_BIT];
      int_ratio <= nxt_int_ratio;
      frac_word <= {upper_word[`OCS_FRAC_HI_MSB:`OCS_FRAC_HI_LSB], lower_word};
      out_mode <= nxt_out_mode;
      clk_run <= (nxt_out_mode == ocs_pkg::OCS_OUT_RUN);
      static_level <= (nxt_out_mode == ocs_pkg::OCS_OUT_HIGH);
      driver <= nxt_driver;
      slew_slow <= driver_word[`OCS_SLEW_BIT];
      pos_en <= driver_word[`OCS_POS_EN_BIT];
      // misuse is only reported; the level is still passed on as written
      neg_en <= driver_word[`OCS_NEG_EN_BIT];
      neg_without_pos <= driver_word[`OCS_NEG_EN_BIT] & ~driver_word[`OCS_POS_EN_BIT];
      supply_high <= driver_word[`OCS_SUPPLY_BIT];
    end
  end
endmodule : ocs_chan_decode

// ==== hdl/ocs_top.sv ====
`timescale 1ns/1ps
`include "ocs_params.svh"
module ocs_top #(
  parameter int NCH = 2
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  output logic [NCH-1:0][1:0] CH_PRESCALE_RATIO,
  output logic [NCH-1:0] CH_PRESCALE_BAD,
  output logic [NCH-1:0] CH_FRAC_EN,
  output logic [NCH-1:0][8:0] CH_INT_RATIO,
  output logic [NCH-1:0][19:0] CH_FRAC_WORD,
  output ocs_pkg::ocs_mode_e CH_OUT_MODE [NCH],
  output logic [NCH-1:0] CH_CLK_RUN,
  output logic [NCH-1:0] CH_STATIC_LEVEL,
  output ocs_pkg::ocs_drv_e CH_DRIVER [NCH],
  output logic [NCH-1:0] CH_SLEW_SLOW,
  output logic [NCH-1:0] CH_POS_EN,
  output logic [NCH-1:0] CH_NEG_EN,
  output logic [NCH-1:0] CH_NEG_WITHOUT_POS,
  output logic [NCH-1:0] CH_SUPPLY_HIGH
);
  localparam int NREG = 3 * NCH;

  // ==========================================================
  // register map: driver, upper divider, lower fraction per channel
  logic [7:0] reg_ofs [NREG];
  logic [15:0] reg_mask [NREG];
  logic [15:0] reg_ff [NREG];
  logic [15:0] nxt_reg [NREG];
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  // channel seven's words sit right after its own driver word
  always_comb begin
    reg_ofs[0] = `OCS_SIX_DRIVER_OFS;
    reg_ofs[1] = `OCS_SIX_UPPER_OFS;
    reg_ofs[2] = `OCS_SIX_LOWER_OFS;
    reg_ofs[3] = `OCS_SEVEN_DRIVER_OFS;
    reg_ofs[4] = `OCS_SEVEN_UPPER_OFS;
    reg_ofs[5] = `OCS_SEVEN_LOWER_OFS;
    for (int i = 0; i < NREG; i++) begin
      unique case (i % 3)
        0: reg_mask[i] = `OCS_DRIVER_MASK;
        1: reg_mask[i] = `OCS_UPPER_MASK;
        default: reg_mask[i] = `OCS_LOWER_MASK;
      endcase
    end
  end

  // ==========================================================
  // write and read decode
  always_comb begin
    nxt_rdata = 16'h0000;
    nxt_rvalid = REG_RD;
    for (int i = 0; i < NREG; i++) begin
      nxt_reg[i] = reg_ff[i];
      // reserved bits are dropped on write so they always read zero
      if (REG_WR && REG_ADDR == reg_ofs[i]) begin
        nxt_reg[i] = REG_WDATA & reg_mask[i];
      end
      if (REG_RD && REG_ADDR == reg_ofs[i]) begin
        nxt_rdata = reg_ff[i];
      end
    end
  end

  // register storage and read answer
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < NREG; i++) begin
        reg_ff[i] <= `OCS_REG_RESET;
      end
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        reg_ff[i] <= nxt_reg[i];
      end
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign REG_RVALID = rvalid_ff;

  // ==========================================================
  // per-channel decode and checks
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      localparam logic [7:0] DRV_OFS = (ch == 0) ? `OCS_SIX_DRIVER_OFS : `OCS_SEVEN_DRIVER_OFS;
      localparam logic [7:0] UPR_OFS = (ch == 0) ? `OCS_SIX_UPPER_OFS : `OCS_SEVEN_UPPER_OFS;
      localparam logic [7:0] LWR_OFS = (ch == 0) ? `OCS_SIX_LOWER_OFS : `OCS_SEVEN_LOWER_OFS;

      // one decode per channel, identical layout for both
      ocs_chan_decode u_dec (
        .clk(CLK),
        .reset(RESET),
        .driver_word(reg_ff[3*ch]),
        .upper_word(reg_ff[3*ch+1]),
        .lower_word(reg_ff[3*ch+2]),
        .prescale_ratio(CH_PRESCALE_RATIO[ch]),
        .prescale_bad(CH_PRESCALE_BAD[ch]),
        .frac_en(CH_FRAC_EN[ch]),
        .int_ratio(CH_INT_RATIO[ch]),
        .frac_word(CH_FRAC_WORD[ch]),
        .out_mode(CH_OUT_MODE[ch]),
        .clk_run(CH_CLK_RUN[ch]),
        .static_level(CH_STATIC_LEVEL[ch]),
        .driver(CH_DRIVER[ch]),
        .slew_slow(CH_SLEW_SLOW[ch]),
        .pos_en(CH_POS_EN[ch]),
        .neg_en(CH_NEG_EN[ch]),
        .neg_without_pos(CH_NEG_WITHOUT_POS[ch]),
        .supply_high(CH_SUPPLY_HIGH[ch])
      );

      // a driver or upper divider word write and its settling into decoded outputs
      sequence drv_write_s;
        REG_WR && REG_ADDR == DRV_OFS;
      endsequence
      sequence upr_write_s;
        REG_WR && REG_ADDR == UPR_OFS;
      endsequence

      prescale_three_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[9] && REG_WDATA[12:10] == 3'h1 |-> ##2 CH_PRESCALE_RATIO[ch] == 2'h3)
        else $error("prescale code one not divide by three");
      prescale_bypass_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and !REG_WDATA[9] |-> ##2 CH_PRESCALE_RATIO[ch] == 2'h1 && !CH_PRESCALE_BAD[ch])
        else $error("prescaler not bypassed with fraction off");
      frac_enable_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s |-> ##2 CH_FRAC_EN[ch] == $past(REG_WDATA[9], 2))
        else $error("fraction enable does not follow bit nine");
      int_ratio_a: assert property (@(posedge CLK) disable iff (RESET)
        upr_write_s |-> ##2 CH_INT_RATIO[ch] == {1'b0, $past(REG_WDATA[11:4], 2)} + 9'h001)
        else $error("integer ratio is not field plus one");
      frac_upper_a: assert property (@(posedge CLK) disable iff (RESET)
        upr_write_s |-> ##2 CH_FRAC_WORD[ch][19:16] == $past(REG_WDATA[3:0], 2))
        else $error("fraction upper nibble misplaced");
      frac_lower_a: assert property (@(posedge CLK) disable iff (RESET)
        REG_WR && REG_ADDR == LWR_OFS |-> ##2 CH_FRAC_WORD[ch][15:0] == $past(REG_WDATA, 2))
        else $error("fraction lower word misplaced");
      static_high_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[2:1] == 2'h3 |-> ##2 CH_STATIC_LEVEL[ch] && !CH_CLK_RUN[ch])
        else $error("static high mode not held high");
      driver_cmos_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[4:3] == 2'h2 |-> ##2 CH_DRIVER[ch] == ocs_pkg::OCS_DRV_CMOS)
        else $error("driver type code two not single-ended");
      slew_slow_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s |-> ##2 CH_SLEW_SLOW[ch] == $past(REG_WDATA[8], 2))
        else $error("slew does not follow bit eight");

      // remaining prescale codes, the reserved ones report rather than divide
      prescale_two_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[9] && REG_WDATA[12:10] == `OCS_PRE_DIV2
        |-> ##2 CH_PRESCALE_RATIO[ch] == `OCS_RATIO_TWO && !CH_PRESCALE_BAD[ch])
        else $error("prescale code zero not divide by two");
      prescale_one_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[9] && REG_WDATA[12:10] == `OCS_PRE_DIV1
        |-> ##2 CH_PRESCALE_RATIO[ch] == `OCS_RATIO_ONE && !CH_PRESCALE_BAD[ch])
        else $error("prescale code seven not divide by one");
      prescale_reserved_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[9] && REG_WDATA[12:10] inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6}
        |-> ##2 CH_PRESCALE_BAD[ch] && CH_PRESCALE_RATIO[ch] == `OCS_RATIO_ONE)
        else $error("reserved prescale code not reported");

      // the other three enable modes
      off_mode_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[2:1] == 2'h0
        |-> ##2 CH_OUT_MODE[ch] == ocs_pkg::OCS_OUT_OFF && !CH_CLK_RUN[ch] && !CH_STATIC_LEVEL[ch])
        else $error("disabled mode not off");
      run_mode_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[2:1] == 2'h1
        |-> ##2 CH_OUT_MODE[ch] == ocs_pkg::OCS_OUT_RUN && CH_CLK_RUN[ch] && !CH_STATIC_LEVEL[ch])
        else $error("run mode not running");
      static_low_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[2:1] == 2'h2
        |-> ##2 CH_OUT_MODE[ch] == ocs_pkg::OCS_OUT_LOW && !CH_CLK_RUN[ch] && !CH_STATIC_LEVEL[ch])
        else $error("static low mode not held low");

      // driver families and the supply and misuse bits
      driver_hcsl_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and REG_WDATA[4:3] == 2'h3 |-> ##2 CH_DRIVER[ch] == ocs_pkg::OCS_DRV_HCSL)
        else $error("driver type code three not current-steering");
      driver_diff_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s and !REG_WDATA[4] |-> ##2 CH_DRIVER[ch] == ocs_pkg::OCS_DRV_DIFF)
        else $error("driver type codes zero and one not differential");
      supply_range_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s |-> ##2 CH_SUPPLY_HIGH[ch] == $past(REG_WDATA[0], 2))
        else $error("supply range does not follow bit zero");
      neg_flag_a: assert property (@(posedge CLK) disable iff (RESET)
        drv_write_s |-> ##2 CH_NEG_WITHOUT_POS[ch] == ($past(REG_WDATA[7], 2) && !$past(REG_WDATA[6], 2)))
        else $error("negative enable misuse not flagged");

      // decoded outputs fall back to the neutral settings under reset
      reset_decode_a: assert property (@(posedge CLK)
        RESET |=> CH_INT_RATIO[ch] == 9'h001 && CH_FRAC_WORD[ch] == 20'h00000
        && CH_PRESCALE_RATIO[ch] == `OCS_RATIO_ONE && CH_OUT_MODE[ch] == ocs_pkg::OCS_OUT_OFF)
        else $error("decoded outputs not neutral after reset");
    end
  endgenerate

  // ==========================================================
  // read port checks
  // a write followed at once by a read of the same driver word
  sequence six_drv_write_s;
    REG_WR && REG_ADDR == `OCS_SIX_DRIVER_OFS;
  endsequence
  sequence six_drv_read_s;
    REG_RD && REG_ADDR == `OCS_SIX_DRIVER_OFS && !REG_WR;
  endsequence

  read_answer_a: assert property (@(posedge CLK) disable iff (RESET)
    REG_RD |=> REG_RVALID)
    else $error("read not answered one cycle later");
  read_idle_a: assert property (@(posedge CLK) disable iff (RESET)
    !REG_RD |=> !REG_RVALID && REG_RDATA == 16'h0000)
    else $error("read answer without a read");
  unmapped_read_a: assert property (@(posedge CLK) disable iff (RESET)
    REG_RD && (REG_ADDR < `OCS_SIX_DRIVER_OFS || REG_ADDR > `OCS_SEVEN_LOWER_OFS) |=> REG_RDATA == 16'h0000)
    else $error("unmapped address does not read zero");
  // the read must see the word taken one edge before, masked
  readback_mask_a: assert property (@(posedge CLK) disable iff (RESET)
    six_drv_write_s ##1 six_drv_read_s
    |=> REG_RVALID && REG_RDATA == ($past(REG_WDATA, 2) & `OCS_DRIVER_MASK))
    else $error("driver word does not read back as written");
endmodule : ocs_top

// ==== verif/ocs_host.sv ====
`timescale 1ns/1ps
`include "ocs_params.svh"
// ==========================================================
// host side of the register port, drives at the falling edge
module ocs_host (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one write; raw lets a scenario break the software rules on purpose
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic raw);
    logic [15:0] v;
    v = d;
    if (!raw && (a == `OCS_SIX_DRIVER_OFS || a == `OCS_SEVEN_DRIVER_OFS)) begin
      v = v & `OCS_DRIVER_MASK;
      v[7] = v[7] & v[6];
    end else if (!raw && (a == `OCS_SIX_UPPER_OFS || a == `OCS_SEVEN_UPPER_OFS)) begin
      v = v & `OCS_UPPER_MASK;
    end
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // released lines show garbage so stale values cannot pass
    reg_wdata = ~v;
    reg_addr = ~a;
  endtask : wr

  // one read; the answer is registered at the take edge and sampled at the falling edge half a cycle later
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd

  // write then read the same word on the very next edge; data goes out unmasked
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q, output logic ok);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
    ok = reg_rvalid;
    q = reg_rdata;
  endtask : wr_rd
endmodule : ocs_host

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`include "ocs_params.svh"
module testbench;
  typedef struct packed {logic [15:0] w; logic [1:0] ratio; logic bad; logic [1:0] drv;} ocs_row_s;
  logic clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic reg_wr;
  logic reg_rd;
  logic reg_rvalid;
  logic ok_b2b;
  logic [1:0][1:0] ch_ratio;
  logic [1:0][8:0] ch_int;
  logic [1:0][19:0] ch_frac;
  logic [1:0] ch_bad, ch_fen, ch_run, ch_stat, ch_slew, ch_pos, ch_neg, ch_nwp, ch_sup;
  ocs_pkg::ocs_mode_e ch_mode [2];
  ocs_pkg::ocs_drv_e ch_drv [2];
  int fails = 0;
  int n_checks = 0;
  int c;
  logic [7:0] a;
  // word, prescale ratio, bad code flag, driver family; even rows channel six
  ocs_row_s rows [6] = '{'{16'h0200, 2'h2, 1'b0, 2'h0}, '{16'h0603, 2'h3, 1'b0, 2'h0},
    '{16'h1e0c, 2'h1, 1'b0, 2'h0}, '{16'h1316, 2'h1, 1'b1, 2'h1},
    '{16'h0c18, 2'h1, 1'b0, 2'h2}, '{16'h00c2, 2'h1, 1'b0, 2'h0}};

  // ==========================================================
  // clock, design and host
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ocs_top #(.NCH(2)) i_ocs_top (.CLK(clk), .RESET(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .CH_PRESCALE_RATIO(ch_ratio), .CH_PRESCALE_BAD(ch_bad), .CH_FRAC_EN(ch_fen), .CH_INT_RATIO(ch_int),
    .CH_FRAC_WORD(ch_frac), .CH_OUT_MODE(ch_mode), .CH_CLK_RUN(ch_run), .CH_STATIC_LEVEL(ch_stat),
    .CH_DRIVER(ch_drv), .CH_SLEW_SLOW(ch_slew), .CH_POS_EN(ch_pos), .CH_NEG_EN(ch_neg),
    .CH_NEG_WITHOUT_POS(ch_nwp), .CH_SUPPLY_HIGH(ch_sup));
  ocs_host i_ocs_host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // ==========================================================
  // checking helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] ad, input logic [15:0] exp);
    logic ok;
    i_ocs_host.rd(ad, rd_val, ok);
    chk("rvalid", ok, 1'b1);
    chk("rdata", rd_val, exp);
  endtask : rdchk

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // watchdog so a hung bus cannot stall the run
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("timeout reached");
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int r = 0; r < 6; r++) begin
      c = r % 2;
      a = c ? `OCS_SEVEN_DRIVER_OFS : `OCS_SIX_DRIVER_OFS;
      i_ocs_host.wr(a, rows[r].w, 1'b0);
      @(negedge clk);
      chk("ratio", ch_ratio[c], rows[r].ratio);
      chk("bad code", ch_bad[c], rows[r].bad);
      chk("frac enable", ch_fen[c], rows[r].w[9]);
      chk("mode", ch_mode[c], rows[r].w[2:1]);
      chk("run", ch_run[c], rows[r].w[2:1] == 2'h1);
      chk("static", ch_stat[c], rows[r].w[2:1] == 2'h3);
      chk("driver", ch_drv[c], rows[r].drv);
      chk("slew", ch_slew[c], rows[r].w[8]);
      chk("pos neg", {ch_pos[c], ch_neg[c]}, {rows[r].w[6], rows[r].w[7]});
      chk("supply", ch_sup[c], rows[r].w[0]);
      rdchk(a, rows[r].w);
    end
    $display("test table rows done");
    // divider words on both channels, top integer count on seven
    i_ocs_host.wr(`OCS_SIX_UPPER_OFS, 16'hf2a5, 1'b1);
    i_ocs_host.wr(`OCS_SIX_LOWER_OFS, 16'h1234, 1'b0);
    i_ocs_host.wr(`OCS_SEVEN_UPPER_OFS, 16'h0ff0, 1'b0);
    i_ocs_host.wr(`OCS_SEVEN_LOWER_OFS, 16'hffff, 1'b0);
    @(negedge clk);
    chk("int six", ch_int[0], 9'h02b);
    chk("frac six", ch_frac[0], 20'h51234);
    chk("int seven", ch_int[1], 9'h100);
    chk("frac seven", ch_frac[1], 20'h0ffff);
    rdchk(`OCS_SIX_UPPER_OFS, 16'h02a5);
    $display("test divider words done");
    // reserved driver bits dropped, unmapped place ignored
    i_ocs_host.wr_rd(`OCS_SIX_DRIVER_OFS, 16'hffff, rd_val, ok_b2b);
    chk("b2b rvalid", ok_b2b, 1'b1);
    chk("b2b rdata", rd_val, 16'h1fdf);
    i_ocs_host.wr(8'h0e, 16'hffff, 1'b1);
    rdchk(`OCS_SIX_DRIVER_OFS, 16'h1fdf);
    rdchk(8'h0e, 16'h0000);
    rdchk(8'h15, 16'h0000);
    $display("test reserved and unmapped done");
    // negative side without positive side is flagged
    i_ocs_host.wr(`OCS_SEVEN_DRIVER_OFS, 16'h0080, 1'b1);
    @(negedge clk);
    chk("misuse flag", ch_nwp[1], 1'b1);
    chk("neg passed", ch_neg[1], 1'b1);
    chk("six flag", ch_nwp[0], 1'b0);
    i_ocs_host.wr(`OCS_SEVEN_DRIVER_OFS, 16'h0080, 1'b0);
    rdchk(`OCS_SEVEN_DRIVER_OFS, 16'h0000);
    $display("test single ended enables done");
    // reset in mid-run clears every register; outputs go neutral, both ratios back to one
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk("ratio reset", ch_ratio, 4'h5);
    chk("int reset", ch_int, 18'h00201);
    chk("frac reset six", ch_frac[0], 20'h00000);
    chk("frac reset seven", ch_frac[1], 20'h00000);
    chk("mode reset", {ch_mode[1], ch_mode[0]}, 4'h0);
    chk("rvalid reset", reg_rvalid, 1'b0);
    chk("rdata reset", reg_rdata, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      rdchk(8'h0f + 8'(k), 16'h0000);
    end
    $display("test reset done");
    close_out();
  end
endmodule : testbench
